// *** rtl/ifc_status.sv ***
// two-wire frame format, master clock divider and status register
//
// Implementation choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "ifc_defs.svh"
`default_nettype none

module ifc_status
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        hw_standby,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_cyc_i,
   output logic             wb_ack_o,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   input  wire logic        arb_lost_pulse,
   input  wire logic        addr_match_pulse,
   input  wire logic        gen_call_pulse,
   output logic             irq_out
);

   // divide ratio for the master serial clock
   function automatic logic [8:0] div_ratio(input logic range,
                                             input logic [2:0] sel);
      logic [8:0] r;
      r = 9'h000;
      unique case ({range, sel})
         4'h0: r = `IFC_DIV0_0;
         4'h1: r = `IFC_DIV0_1;
         4'h2: r = `IFC_DIV0_2;
         4'h3: r = `IFC_DIV0_3;
         4'h4: r = `IFC_DIV0_4;
         4'h5: r = `IFC_DIV0_5;
         4'h6: r = `IFC_DIV0_6;
         4'h7: r = `IFC_DIV0_7;
         4'h8: r = `IFC_DIV1_0;
         4'h9: r = `IFC_DIV1_1;
         4'hA: r = `IFC_DIV1_2;
         4'hB: r = `IFC_DIV1_3;
         4'hC: r = `IFC_DIV1_4;
         4'hD: r = `IFC_DIV1_5;
         4'hE: r = `IFC_DIV1_6;
         4'hF: r = `IFC_DIV1_7;
      endcase
      return r;
   endfunction

   // software visible state
   logic [7:0]  ctrl, next_ctrl;
   logic [7:0]  mode, next_mode;
   logic        range, next_range;
   logic        fmt, next_fmt;
   logic        busy, next_busy;
   logic        acknowledge_bit_value, next_acknowledge_bit_value;
   logic [3:0]  flg, next_flg;       // irq, al, aas, adz
   logic [3:0]  arm, next_arm;       // read while set seen
   logic        start_pend, next_start_pend;
   logic        stop_pend, next_stop_pend;
   logic        ack, next_ack;
   logic [31:0] rdat, next_rdat;
   // bus monitor state
   logic        scl_q, sda_q;
   logic [3:0]  bit_cnt, next_bit_cnt;
   logic        addressed, next_addressed;
   logic        in_wait, next_in_wait;
   // master engine state
   ifc_pkg::ifc_eng_type eng, next_eng;
   logic [7:0]  div_cnt, next_div_cnt;
   logic        scl_lo, next_scl_lo;

   logic        enable, master, serial, wait_ins, irq_en;
   logic        access, wr_status, rd_status;
   logic [7:0]  wdat, status_view;
   logic        start_det, stop_det, scl_rise, scl_fall;
   logic [3:0]  data_bits, frame_len;
   logic        frame_end, wait_point, xfer_done;
   logic [3:0]  clr_ev, set_ev;
   logic [3:0]  rd_seen;             // flag read back as one
   logic [7:0]  half_m1;
   logic        tick;

   assign enable   = ctrl[`IFC_CT_ENABLE];
   assign master   = ctrl[`IFC_CT_MASTER];
   assign serial   = ctrl[`IFC_CT_SERIAL];
   assign irq_en   = ctrl[`IFC_CT_IRQ_EN];
   assign wait_ins = mode[`IFC_MD_WAIT];
   assign wdat     = wb_dat_i[7:0];

   // a request takes effect at the edge where ack is seen high
   assign access    = wb_cyc_i & wb_stb_i & ack;
   assign wr_status = access & wb_we_i & wb_sel_i[0]
                      & (wb_adr_i == `IFC_OFS_STATUS);
   assign rd_status = access & ~wb_we_i & (wb_adr_i == `IFC_OFS_STATUS);

   // status read image, fixed one bits included
   // strobe reads one
   assign status_view = {busy, flg[3], 1'b1, 1'b1, flg[2], flg[1],
                         flg[0], acknowledge_bit_value};

   // start and stop detection on sampled lines
   assign start_det = scl_i & scl_q & sda_q & ~sda_i;
   assign stop_det  = scl_i & scl_q & ~sda_q & sda_i;
   assign scl_rise  = scl_i & ~scl_q;
   assign scl_fall  = ~scl_i & scl_q;

   // frame length from bit count and framing
   // zero count means eight bits
   assign data_bits = (mode[2:0] == 3'b000) ? 4'h8 : {1'b0, mode[2:0]};
   // acknowledge bit only in acknowledge framing
   assign frame_len  = data_bits + {3'b000, ~serial};
   assign frame_end  = enable & scl_fall & (bit_cnt == frame_len);
   assign wait_point = enable & scl_fall & ~serial & wait_ins
                       & (bit_cnt == data_bits);
   // event point follows framing and wait insertion
   assign xfer_done = (~serial & wait_ins) ? wait_point : frame_end;

   // flag set events: irq, al, aas, adz
   // irq sources per mode
   assign set_ev[3] = (master & (xfer_done | arb_lost_pulse))
                      | (~master & fmt & xfer_done)
                      | (~master & ~fmt
                         & (addr_match_pulse | gen_call_pulse
                            | (addressed & xfer_done)));
   assign set_ev[2] = master & arb_lost_pulse;
   assign set_ev[1] = ~master & ~fmt & (addr_match_pulse | gen_call_pulse);
   assign set_ev[0] = ~master & ~fmt & gen_call_pulse;

   // per flag clear: armed by a read while set, then a zero write
   generate
      for (genvar gi = 0; gi < 4; gi++)
      begin : g_flag
         localparam int POS = (gi == 3) ? `IFC_ST_IRQ :
                              (gi == 2) ? `IFC_ST_AL :
                              (gi == 1) ? `IFC_ST_AAS : `IFC_ST_ADZ;
         // zero clears only after a read
         assign clr_ev[gi] = wr_status & arm[gi] & ~wdat[POS];
         // arm only on the image software really saw
         assign rd_seen[gi] = rd_status & rdat[POS];
      end
   endgenerate

   // register file and flag next values
   always_comb
   begin
      next_ctrl       = ctrl;
      next_mode       = mode;
      next_range      = range;
      next_fmt        = fmt;
      next_acknowledge_bit_value       = acknowledge_bit_value;
      next_start_pend = start_pend;
      next_stop_pend  = stop_pend;
      next_ack        = wb_cyc_i & wb_stb_i & ~ack;
      next_rdat       = rdat;
      if (next_ack & ~wb_we_i)
      begin
         unique case (wb_adr_i)
            `IFC_OFS_STATUS:  next_rdat = {24'h000000, status_view};
            `IFC_OFS_CONTROL: next_rdat = {24'h000000, ctrl};
            `IFC_OFS_MODE:    next_rdat = {24'h000000, mode};
            `IFC_OFS_TIMER:   next_rdat = {31'h00000000, range};
            `IFC_OFS_SLAVE:   next_rdat = {31'h00000000, fmt};
            default:          next_rdat = 32'h00000000;
         endcase
      end
      if (access & wb_we_i & wb_sel_i[0])
      begin
         unique case (wb_adr_i)
            `IFC_OFS_CONTROL: next_ctrl  = wdat;
            `IFC_OFS_MODE:    next_mode  = wdat | `IFC_MODE_FIXED;
            `IFC_OFS_TIMER:   next_range = wdat[`IFC_TM_RANGE];
            `IFC_OFS_SLAVE:   next_fmt   = wdat[`IFC_SL_FORMAT];
            default:          next_acknowledge_bit_value  = acknowledge_bit_value;
         endcase
      end
      if (wr_status)
      begin
         next_acknowledge_bit_value = wdat[`IFC_ST_ACKNOWLEDGE_BIT_VALUE];
         if (master & enable & ~wdat[`IFC_ST_STROBE])
         begin
            next_start_pend = wdat[`IFC_ST_BUSY];
            next_stop_pend  = ~wdat[`IFC_ST_BUSY];
         end
      end
      // arbitration loss falls back to slave receive
      if (arb_lost_pulse)
      begin
         next_ctrl[`IFC_CT_MASTER]   = 1'b0;
         next_ctrl[`IFC_CT_TRANSMIT] = 1'b0;
      end
      if (eng == ifc_pkg::ENG_IDLE || tick)
      begin
         if (next_eng == ifc_pkg::ENG_START_HOLD)
            next_start_pend = 1'b0;
         if (next_eng == ifc_pkg::ENG_STOP_LOW)
            next_stop_pend = 1'b0;
      end
      // set wins over clear
      next_flg = set_ev | (flg & ~clr_ev);
      for (int i = 0; i < 4; i++)
      begin
         if (wr_status | ~flg[i])
            next_arm[i] = 1'b0;
         else if (rd_seen[i])
            next_arm[i] = 1'b1;
         else
            next_arm[i] = arm[i];
      end
      next_busy = start_det ? 1'b1 : (stop_det ? 1'b0 : busy);
   end

   // bus monitor next values
   always_comb
   begin
      next_bit_cnt   = bit_cnt;
      next_addressed = addressed;
      next_in_wait   = in_wait;
      if (start_det | stop_det | ~enable)
      begin
         next_bit_cnt   = 4'h0;
         next_addressed = 1'b0;
         next_in_wait   = 1'b0;
      end
      else
      begin
         if (frame_end)
            next_bit_cnt = 4'h0;
         else if (scl_rise)
            next_bit_cnt = bit_cnt + 4'h1;
         if (~master & ~fmt & (addr_match_pulse | gen_call_pulse))
            next_addressed = 1'b1;
         if (wait_point)
            next_in_wait = 1'b1;
         else if (~flg[3])
            next_in_wait = 1'b0;
      end
   end

   // half period of the selected ratio
   assign half_m1 = 8'(div_ratio(range, ctrl[2:0]) >> 1) - 8'h01;
   // one tick per half period, master only
   assign tick = (eng != ifc_pkg::ENG_IDLE) & (div_cnt == half_m1);

   // master condition and clock engine next values
   always_comb
   begin
      next_eng     = eng;
      next_scl_lo  = scl_lo;
      next_div_cnt = tick ? 8'h00 : div_cnt + 8'h01;
      unique case (eng)
         ifc_pkg::ENG_IDLE:
         begin
            next_div_cnt = 8'h00;
            next_scl_lo  = 1'b0;
            if (start_pend)
               next_eng = ifc_pkg::ENG_START_HOLD;
         end
         ifc_pkg::ENG_START_HOLD:
            if (tick)
            begin
               next_eng    = ifc_pkg::ENG_RUN;
               next_scl_lo = 1'b1;
            end
         ifc_pkg::ENG_RUN:
            if (tick)
            begin
               if (scl_lo & stop_pend)
                  next_eng = ifc_pkg::ENG_STOP_LOW;
               else if (scl_lo & start_pend)
                  next_eng = ifc_pkg::ENG_RS_LOW;
               else if (~(scl_lo & in_wait & flg[3]))
                  next_scl_lo = ~scl_lo;
            end
         ifc_pkg::ENG_RS_LOW:
            if (tick)
            begin
               next_eng    = ifc_pkg::ENG_RS_HIGH;
               next_scl_lo = 1'b0;
            end
         ifc_pkg::ENG_RS_HIGH:
            if (tick)
               next_eng = ifc_pkg::ENG_START_HOLD;
         ifc_pkg::ENG_STOP_LOW:
            if (tick)
            begin
               next_eng    = ifc_pkg::ENG_STOP_HIGH;
               next_scl_lo = 1'b0;
            end
         ifc_pkg::ENG_STOP_HIGH:
            if (tick)
               next_eng = ifc_pkg::ENG_IDLE;
      endcase
      if (~master | ~enable)
         next_eng = ifc_pkg::ENG_IDLE;
   end

   // registers of all groups
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl       <= `IFC_CONTROL_RESET;
         mode       <= `IFC_MODE_RESET;
         range      <= 1'b0;
         fmt        <= 1'b0;
         busy       <= 1'b0;
         acknowledge_bit_value       <= 1'b0;
         flg        <= 4'h0;
         arm        <= 4'h0;
         start_pend <= 1'b0;
         stop_pend  <= 1'b0;
         ack        <= 1'b0;
         rdat       <= 32'h00000000;
         scl_q      <= 1'b1;
         sda_q      <= 1'b1;
         bit_cnt    <= 4'h0;
         addressed  <= 1'b0;
         in_wait    <= 1'b0;
         eng        <= ifc_pkg::ENG_IDLE;
         div_cnt    <= 8'h00;
         scl_lo     <= 1'b0;
      end
      else
      begin
         ctrl       <= next_ctrl;
         mode       <= next_mode;
         range      <= next_range;
         fmt        <= next_fmt;
         start_pend <= next_start_pend;
         stop_pend  <= next_stop_pend;
         ack        <= next_ack;
         rdat       <= next_rdat;
         scl_q      <= scl_i;
         sda_q      <= sda_i;
         bit_cnt    <= next_bit_cnt;
         addressed  <= next_addressed;
         in_wait    <= next_in_wait;
         eng        <= next_eng;
         div_cnt    <= next_div_cnt;
         scl_lo     <= next_scl_lo;
         if (hw_standby)
         begin
            busy <= 1'b0;
            acknowledge_bit_value <= 1'b0;
            flg  <= 4'h0;
            arm  <= 4'h0;
         end
         else
         begin
            busy <= next_busy;
            acknowledge_bit_value <= next_acknowledge_bit_value;
            flg  <= next_flg;
            arm  <= next_arm;
         end
      end
   end

   // open-drain pins: low when enabled
   assign scl_o  = 1'b0;
   assign sda_o  = 1'b0;
   assign scl_oe = enable & (scl_lo | (in_wait & flg[3])
                   | (eng == ifc_pkg::ENG_STOP_LOW));
   assign sda_oe = enable & ((eng == ifc_pkg::ENG_START_HOLD)
                   | (eng == ifc_pkg::ENG_STOP_LOW)
                   | (eng == ifc_pkg::ENG_STOP_HIGH));
   assign wb_ack_o = ack;
   assign wb_dat_o = rdat;
   assign irq_out = flg[3] & irq_en;

   // assertions share the system clock and reset
   default clocking cb_sys @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   // start write in master mode then start drive
   sequence s_start_write;
      wr_status && master && enable && wdat[7] && !wdat[5]
         && eng == ifc_pkg::ENG_IDLE;
   endsequence
   sequence s_start_drive;
      ##2 (sda_oe && !scl_oe);
   endsequence

   a_start_issue: assert property (s_start_write |-> s_start_drive)
      else $error("start write did not drive a start");
   a_stop_issue: assert property (
      wr_status && master && enable && !wdat[7] && !wdat[5]
      |=> stop_pend || eng == ifc_pkg::ENG_STOP_LOW)
      else $error("stop write not taken");
   a_slave_nowrite: assert property (
      wr_status && !master && !start_pend && !stop_pend
      |=> !start_pend && !stop_pend)
      else $error("slave busy write issued a condition");
   a_busy_start: assert property (start_det && !hw_standby |=> busy)
      else $error("start seen but bus not busy");
   a_busy_stop: assert property (stop_det |=> !busy)
      else $error("stop seen but bus still busy");
   a_irq_keep: assert property (
      flg[3] && wr_status && !arm[3] && !hw_standby |=> flg[3])
      else $error("irq flag cleared without prior read");
   a_fixed_ones: assert property (rd_status |=> rdat[5:4] == 2'b11)
      else $error("status fixed bits not read as one");
   a_irq_gate: assert property ($rose(flg[3]) |-> irq_out == irq_en)
      else $error("interrupt output not gated by enable");
   a_frame_irq: assert property (
      master && frame_end && (serial || !wait_ins) && !hw_standby
      |=> flg[3])
      else $error("irq flag not set at frame end");
   a_scl_phase: assert property (
      $changed(scl_lo) && eng == ifc_pkg::ENG_RUN
      && $past(eng) == ifc_pkg::ENG_RUN
      |-> $past(div_cnt) == $past(half_m1))
      else $error("scl phase not one half period");

endmodule

`default_nettype wire

// *** rtl/ifc_defs.svh ***
// register offsets, field positions, reset values and divider ratios
`ifndef IFC_DEFS_SVH
`define IFC_DEFS_SVH

// register byte offsets on the wishbone bus
`define IFC_OFS_STATUS   8'h00
`define IFC_OFS_CONTROL  8'h04
`define IFC_OFS_MODE     8'h08
`define IFC_OFS_TIMER    8'h0C
`define IFC_OFS_SLAVE    8'h10

// bus_status_reg fields
`define IFC_ST_BUSY      7
`define IFC_ST_IRQ       6
`define IFC_ST_STROBE    5
`define IFC_ST_FIXED     4
`define IFC_ST_AL        3
`define IFC_ST_AAS       2
`define IFC_ST_ADZ       1
`define IFC_ST_ACKNOWLEDGE_BIT_VALUE      0
`define IFC_STATUS_RESET 8'h30

// bus_control_reg fields
`define IFC_CT_ENABLE    7
`define IFC_CT_IRQ_EN    6
`define IFC_CT_MASTER    5
`define IFC_CT_TRANSMIT  4
`define IFC_CT_SERIAL    3
`define IFC_CONTROL_RESET 8'h00

// bus_mode_reg fields
`define IFC_MD_WAIT      6
`define IFC_MODE_RESET   8'h38
`define IFC_MODE_FIXED   8'h38

// serial_timer_control_reg and own_address_reg fields
`define IFC_TM_RANGE     0
`define IFC_SL_FORMAT    0
`define IFC_REG_RESET    8'h00

// peripheral clock divide ratios, range 0 then range 1
`define IFC_DIV0_0 9'h01C
`define IFC_DIV0_1 9'h028
`define IFC_DIV0_2 9'h030
`define IFC_DIV0_3 9'h040
`define IFC_DIV0_4 9'h050
`define IFC_DIV0_5 9'h064
`define IFC_DIV0_6 9'h070
`define IFC_DIV0_7 9'h080
`define IFC_DIV1_0 9'h038
`define IFC_DIV1_1 9'h050
`define IFC_DIV1_2 9'h060
`define IFC_DIV1_3 9'h080
`define IFC_DIV1_4 9'h0A0
`define IFC_DIV1_5 9'h0C8
`define IFC_DIV1_6 9'h0E0
`define IFC_DIV1_7 9'h100

`endif

// *** rtl/ifc_pkg.sv ***
// types shared by the two-wire status block
package ifc_pkg;

   // master condition and clock engine states
   typedef enum logic [2:0] {
      ENG_IDLE,
      ENG_START_HOLD,
      ENG_RUN,
      ENG_RS_LOW,
      ENG_RS_HIGH,
      ENG_STOP_LOW,
      ENG_STOP_HIGH
   } ifc_eng_type;

endpackage

// *** dv/ifc_bus_peer.sv ***
// far-side party on the two-wire bus: pull-ups and a simple master
`timescale 1ns/1ps
`default_nettype none

module ifc_bus_peer
(
   input  wire logic sys_clk,
   input  wire logic scl_oe,
   input  wire logic sda_oe,
   output logic      scl_i,
   output logic      sda_i
);
   logic scl_low;
   logic sda_low;

   // wired-and lines, a released line is pulled high
   assign scl_i = !(scl_oe || scl_low);
   assign sda_i = !(sda_oe || sda_low);

   // bus idle at time zero
   initial
   begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end

   task automatic start_cond(input int half);
      repeat (half) @(posedge sys_clk);
      sda_low <= 1'b1;
      repeat (half) @(posedge sys_clk);
      scl_low <= 1'b1;
   endtask

   // clock n bits, sda held steady, ends with scl low
   task automatic frame(input int n, input int half);
      repeat (n)
      begin
         repeat (half) @(posedge sys_clk);
         scl_low <= 1'b0;
         repeat (half) @(posedge sys_clk);
         scl_low <= 1'b1;
      end
   endtask

   task automatic stop_cond(input int half);
      sda_low <= 1'b1;
      repeat (half) @(posedge sys_clk);
      scl_low <= 1'b0;
      repeat (half) @(posedge sys_clk);
      sda_low <= 1'b0;
   endtask
endmodule

`default_nettype wire

// *** dv/ifc_status_tb.sv ***
// self-checking bench for the two-wire status block
`timescale 1ns/1ps
`include "ifc_defs.svh"
`default_nettype none

`define CHK(what, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         n_errors++; \
         $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); \
      end \
   end

module ifc_status_tb;
   logic        sys_clk;
   logic        rst_n;
   logic        hw_standby;
   logic [7:0]  wb_adr_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic        wb_we_i;
   logic [3:0]  wb_sel_i;
   logic        wb_stb_i;
   logic        wb_cyc_i;
   logic        wb_ack_o;
   logic        scl_i;
   logic        scl_o;
   logic        scl_oe;
   logic        sda_i;
   logic        sda_o;
   logic        sda_oe;
   logic        arb_lost_pulse;
   logic        addr_match_pulse;
   logic        gen_call_pulse;
   logic        irq_out;
   logic [7:0]  q;
   int          n_errors;
   int          samples_checked;
   int          seed;

   ifc_status DUT (.sys_clk(sys_clk), .rst_n(rst_n), .hw_standby(hw_standby),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i),
      .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .scl_i(scl_i),
      .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
      .sda_oe(sda_oe), .arb_lost_pulse(arb_lost_pulse),
      .addr_match_pulse(addr_match_pulse), .gen_call_pulse(gen_call_pulse),
      .irq_out(irq_out));

   ifc_bus_peer peer (.sys_clk(sys_clk), .scl_oe(scl_oe), .sda_oe(sda_oe),
      .scl_i(scl_i), .sda_i(sda_i));

   // 200 MHz clock
   always #2.5 sys_clk = ~sys_clk;

   // one classic wishbone cycle, held until ack is sampled
   task automatic wb_io(input logic [7:0] a, input logic w,
                        input logic [7:0] d);
      int n;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_adr_i <= a;
      wb_we_i  <= w;
      wb_dat_i <= {24'h000000, d};
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 64);
      if (n >= 64) n_errors++;
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb_io(a, 1'b1, d);
   endtask

   task automatic rd(input logic [7:0] a);
      wb_io(a, 1'b0, 8'h00);
   endtask

   function automatic int exp_ratio(input logic r, input logic [2:0] s);
      int t0[8] = '{28, 40, 48, 64, 80, 100, 112, 128};
      int t1[8] = '{56, 80, 96, 128, 160, 200, 224, 256};
      return r ? t1[s] : t0[s];
   endfunction

   // bit count, plus ack bit outside serial framing
   function automatic int exp_bits(input logic [2:0] bc, input logic ser);
      return (bc == 3'h0 ? 8 : int'(bc)) + (ser ? 0 : 1);
   endfunction

   // one master frame from start to stop
   task automatic master_frame(input logic rng, input logic ser,
                               input logic [2:0] sel, input logic [2:0] bc,
                               input logic wt);
      int   st[$];
      int   rises;
      int   low;
      int   t;
      logic scl_d;
      logic oe_d;
      rises = 0;
      low = 0;
      scl_d = 1'b1;
      oe_d = 1'b0;
      wr(`IFC_OFS_TIMER, {7'h00, rng});
      wr(`IFC_OFS_CONTROL, {4'hE, ser, sel});
      wr(`IFC_OFS_MODE, {1'b0, wt, 3'b000, bc});
      wr(`IFC_OFS_STATUS, 8'h80);
      for (t = 0; t < 4000 && irq_out !== 1'b1; t++)
      begin
         @(posedge sys_clk);
         if (scl_i && !scl_d) rises++;
         if (scl_oe && !oe_d) st.push_back(t);
         if (scl_oe && st.size() == 1) low++;
         scl_d = scl_i;
         oe_d = scl_oe;
      end
      `CHK("scl period", exp_ratio(rng, sel), st[1] - st[0])
      `CHK("scl low phase", exp_ratio(rng, sel) / 2, low)
      `CHK("frame bits", exp_bits(bc, ser | wt), rises)
      `CHK("irq at frame end", 1'b1, irq_out)
      if (wt && !ser)
      begin
         repeat (200) @(posedge sys_clk);
         `CHK("scl held in wait", 1'b1, scl_oe)
      end
      rd(`IFC_OFS_STATUS);
      `CHK("busy and irq", 2'b11, q[7:6])
      `CHK("open drain level", 2'b00, {scl_o, sda_o})
      wr(`IFC_OFS_STATUS, 8'h00);
      t = 0;
      do
      begin
         rd(`IFC_OFS_STATUS);
         t++;
      end
      while (q[7] !== 1'b0 && t < 200);
      `CHK("after stop", 8'h30, q)
   endtask

   // verdict and end of run
   task automatic summarize();
      if (n_errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // watchdog against a hang
   initial
   begin
      repeat (60000) @(posedge sys_clk);
      n_errors++;
      summarize();
   end

   // main sequence
   initial
   begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      hw_standby = 1'b0;
      {wb_adr_i, wb_dat_i, wb_we_i, wb_stb_i, wb_cyc_i} = '0;
      wb_sel_i = 4'hF;
      {arb_lost_pulse, addr_match_pulse, gen_call_pulse} = 3'h0;
      n_errors = 0;
      samples_checked = 0;
      seed = 6909;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(`IFC_OFS_STATUS);
      `CHK("status reset", 8'h30, q)
      rd(`IFC_OFS_MODE);
      `CHK("mode reset", 8'h38, q)
      rd(8'h14);
      `CHK("unmapped read", 8'h00, q)
      wr(`IFC_OFS_STATUS, 8'hFF);
      rd(`IFC_OFS_STATUS);
      `CHK("ones write", 8'h31, q)
      wr(`IFC_OFS_CONTROL, 8'h80);
      peer.start_cond(4);
      repeat (4) @(posedge sys_clk);
      wr(`IFC_OFS_STATUS, 8'h00);
      rd(`IFC_OFS_STATUS);
      `CHK("start seen", 8'hB0, q)
      peer.stop_cond(4);
      repeat (4) @(posedge sys_clk);
      rd(`IFC_OFS_STATUS);
      `CHK("stop seen", 8'h30, q)
      @(posedge sys_clk);
      {addr_match_pulse, gen_call_pulse} <= 2'h3;
      @(posedge sys_clk);
      {addr_match_pulse, gen_call_pulse} <= 2'h0;
      repeat (2) @(posedge sys_clk);
      `CHK("irq masked", 1'b0, irq_out)
      wr(`IFC_OFS_STATUS, 8'h00);
      rd(`IFC_OFS_STATUS);
      `CHK("match flags", 8'h76, q)
      wr(`IFC_OFS_CONTROL, 8'hC0);
      repeat (2) @(posedge sys_clk);
      `CHK("irq enabled", 1'b1, irq_out)
      wr(`IFC_OFS_STATUS, 8'h00);
      rd(`IFC_OFS_STATUS);
      `CHK("flags cleared", 8'h30, q)
      wr(`IFC_OFS_SLAVE, 8'h01);
      peer.start_cond(25);
      peer.frame(8, 25);
      `CHK("no irq before ack", 1'b0, irq_out)
      peer.frame(1, 25);
      repeat (3) @(posedge sys_clk);
      `CHK("slave frame irq", 1'b1, irq_out)
      rd(`IFC_OFS_STATUS);
      wr(`IFC_OFS_STATUS, 8'h00);
      peer.stop_cond(25);
      repeat (6) @(posedge sys_clk);
      rd(`IFC_OFS_STATUS);
      `CHK("slave frame done", 8'h30, q)
      wr(`IFC_OFS_SLAVE, 8'h00);
      wr(`IFC_OFS_CONTROL, 8'hA0);
      @(posedge sys_clk);
      arb_lost_pulse <= 1'b1;
      @(posedge sys_clk);
      arb_lost_pulse <= 1'b0;
      rd(`IFC_OFS_STATUS);
      `CHK("arbitration lost", 8'h78, q)
      @(posedge sys_clk);
      hw_standby <= 1'b1;
      @(posedge sys_clk);
      hw_standby <= 1'b0;
      rd(`IFC_OFS_STATUS);
      `CHK("standby image", 8'h30, q)
      master_frame(1'b1, 1'b0, 3'h7, 3'h0, 1'b0);
      master_frame(1'b0, 1'b1, 3'h0, 3'h1, 1'b1);
      master_frame(1'b0, 1'b0, 3'h2, 3'h3, 1'b1);
      repeat (3)
         master_frame(1'($random(seed)), 1'($random(seed)),
                      3'($random(seed)), 3'($random(seed)),
                      1'($random(seed)));
      summarize();
   end
endmodule

`default_nettype wire
